// ---- hdl/wirc_pkg.sv ----
// constants and carrier types for the wake, interrupt and ram-wipe controller
// Notes on behaviour
// - with main supply absent, a falling edge on key_wake_n requests system power-on.
// - key power-on works only with aux_backup_supply present and both enables set to 1.
// - with main supply present, a key_wake_n falling edge is an interrupt source instead.
// - the interrupt pin is active low and open drain, pulling low and never driving high.
// - the interrupt stays low while any status flag is set together with its enable bit.
// - when enabled, user_ram_wipe_n low fills all 242 user ram bytes with FFh.
// - an enabled wipe works whether or not main supply is present.
// - user_ram_wipe_n has an internal pull-up, so an open switch reads inactive.
// - a bus cycle without chip select latches the address but transfers no data.
// - below the power-fail threshold bus inputs are ignored; key wake may still work.
package wirc_pkg;

  // ---------------------------------------------------------------
  // register map (byte addresses, one word each)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_MASK = 8'h08;
  localparam logic [7:0] ADDR_LEVEL = 8'h0C;
  localparam logic [7:0] ADDR_RAM_BASE = 8'h10;
  localparam logic [7:0] ADDR_LAST_ADDR = 8'h14;

  // ---------------------------------------------------------------
  // control fields
  // ---------------------------------------------------------------
  localparam int CTRL_BACKUP_EN = 0;
  localparam int CTRL_KEY_EN = 1;
  localparam int CTRL_WIPE_EN = 2;
  localparam int CTRL_W = 3;
  localparam logic [2:0] CTRL_RESET = 3'h0;

  // status/mask bits
  localparam int ST_KEY_IRQ = 0;
  localparam int ST_POWER_ON = 1;
  localparam int ST_WIPE_DONE = 2;
  localparam int ST_W = 3;
  localparam logic [2:0] MASK_RESET = 3'h0;

  // ram geometry and wipe value
  localparam int RAM_BYTES = 242;
  localparam logic [7:0] WIPE_VALUE = 8'hFF;
  localparam logic [7:0] RAM_LAST = 8'hF1;

  // wishbone read data for unmapped addresses
  localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;

  typedef enum logic [1:0] {
    WIRC_WIPE_IDLE,
    WIRC_WIPE_RUN,
    WIRC_WIPE_HOLD
  } wirc_wipe_t;

  // wishbone request carrier
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] dat;
  } wirc_wb_req_t;

  // pin level inputs after synchronisation
  typedef struct packed {
    logic key_n;
    logic wipe_n;
    logic main_ok;
    logic aux_ok;
  } wirc_pins_t;

endpackage : wirc_pkg

// ---- hdl/wirc_ctrl.sv ----
// wake, interrupt and ram-wipe controller with a classic wishbone slave
//
// Chosen here: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
module wirc_ctrl #(
  parameter int RAM_DEPTH = wirc_pkg::RAM_BYTES
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic chip_sel_n,
  input wire logic main_supply_ok,
  input wire logic aux_backup_supply,
  input wire logic key_wake_n,
  input wire logic user_ram_wipe_n,
  input wire logic user_ram_wipe_pu,
  output logic irq_n_o,
  output logic irq_n_oe,
  output logic power_on_req,
  output logic wipe_busy
);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  wirc_pkg::wirc_pins_t pins_raw;
  wirc_pkg::wirc_pins_t sync1_reg;
  wirc_pkg::wirc_pins_t sync2_reg;
  wirc_pkg::wirc_pins_t sync1_next;
  wirc_pkg::wirc_pins_t sync2_next;
  logic key_prev_reg;
  logic key_prev_next;

  // internal pull-up: a floating wipe pin reads high
  always_comb begin
    pins_raw.key_n = key_wake_n;
    pins_raw.wipe_n = user_ram_wipe_n | user_ram_wipe_pu;
    pins_raw.main_ok = main_supply_ok;
    pins_raw.aux_ok = aux_backup_supply;
  end

  // two-stage sync; only stage two feeds logic
  always_comb begin
    sync1_next = pins_raw;
    sync2_next = sync1_reg;
    key_prev_next = sync2_reg.key_n;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_reg <= '{key_n: 1'b1, wipe_n: 1'b1, main_ok: 1'b0, aux_ok: 1'b0};
      sync2_reg <= '{key_n: 1'b1, wipe_n: 1'b1, main_ok: 1'b0, aux_ok: 1'b0};
      key_prev_reg <= 1'b1;
    end else begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
      key_prev_reg <= key_prev_next;
    end
  end

  logic key_fall;
  assign key_fall = key_prev_reg & ~sync2_reg.key_n;

  // ---------------------------------------------------------------
  // wishbone slave, control, status and mask
  // ---------------------------------------------------------------
  logic [wirc_pkg::CTRL_W-1:0] ctrl_reg;
  logic [wirc_pkg::CTRL_W-1:0] ctrl_next;
  logic [wirc_pkg::ST_W-1:0] status_reg;
  logic [wirc_pkg::ST_W-1:0] status_next;
  logic [wirc_pkg::ST_W-1:0] mask_reg;
  logic [wirc_pkg::ST_W-1:0] mask_next;
  logic [7:0] last_addr_reg;
  logic [7:0] last_addr_next;
  logic ack_next;
  logic [31:0] dat_next;
  logic irq_next;
  logic pwr_reg;
  logic pwr_next;
  logic [wirc_pkg::ST_W-1:0] events;
  logic bus_live;
  logic acc;
  logic wr_ok;
  logic rd_ok;
  logic wipe_done_ev;
  logic [7:0] ram_rd;

  // bus accesses ignored while main supply is below the trip point
  assign bus_live = sync2_reg.main_ok;
  assign acc = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // without chip select the address is kept, data is not moved
  assign wr_ok = acc & wb_we_i & wb_sel_i[0] & bus_live & ~chip_sel_n;
  assign rd_ok = acc & ~wb_we_i & bus_live & ~chip_sel_n;

  // byte-lane write helper, low lane holds all fields
  function automatic logic [2:0] wirc_lane0(input logic [31:0] d);
    wirc_lane0 = d[2:0];
  endfunction : wirc_lane0

  always_comb begin
    ctrl_next = ctrl_reg;
    mask_next = mask_reg;
    last_addr_next = last_addr_reg;
    ack_next = acc;
    dat_next = wirc_pkg::RD_UNMAPPED;
    events = '0;
    // power-on request only on backup power with both enables and aux present
    events[wirc_pkg::ST_POWER_ON] = key_fall & ~sync2_reg.main_ok & sync2_reg.aux_ok
        & ctrl_reg[wirc_pkg::CTRL_BACKUP_EN] & ctrl_reg[wirc_pkg::CTRL_KEY_EN];
    // with main supply the key is an interrupt source
    events[wirc_pkg::ST_KEY_IRQ] = key_fall & sync2_reg.main_ok;
    events[wirc_pkg::ST_WIPE_DONE] = wipe_done_ev;
    status_next = status_reg;
    // address latched on every strobed cycle while main supply is up, chip select or not
    if (acc && bus_live) begin
      last_addr_next = wb_adr_i;
    end
    if (wr_ok) begin
      case (wb_adr_i)
        wirc_pkg::ADDR_CTRL: ctrl_next = wirc_lane0(wb_dat_i);
        wirc_pkg::ADDR_MASK: mask_next = wirc_lane0(wb_dat_i);
        default: ;
      endcase
    end
    if (rd_ok) begin
      case (wb_adr_i)
        wirc_pkg::ADDR_CTRL: dat_next = {29'h0, ctrl_reg};
        wirc_pkg::ADDR_STATUS: begin
          dat_next = {29'h0, status_reg};
          // read clears flags; host must clear all contributors
          status_next = '0;
        end
        wirc_pkg::ADDR_MASK: dat_next = {29'h0, mask_reg};
        wirc_pkg::ADDR_LEVEL: dat_next = {28'h0, sync2_reg};
        wirc_pkg::ADDR_RAM_BASE: dat_next = {24'h0, ram_rd};
        wirc_pkg::ADDR_LAST_ADDR: dat_next = {24'h0, last_addr_reg};
        default: dat_next = wirc_pkg::RD_UNMAPPED;
      endcase
    end
    // set wins over read clear
    status_next = status_next | events;
    // low while any flag and its enable are both set
    irq_next = ~|(status_next & mask_next);
    // power-on request held until main supply returns
    pwr_next = (pwr_reg | events[wirc_pkg::ST_POWER_ON]) & ~sync2_reg.main_ok;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_reg <= wirc_pkg::CTRL_RESET;
      status_reg <= '0;
      mask_reg <= wirc_pkg::MASK_RESET;
      last_addr_reg <= 8'h00;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      irq_n_o <= 1'b1;
      irq_n_oe <= 1'b0;
      pwr_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      status_reg <= status_next;
      mask_reg <= mask_next;
      last_addr_reg <= last_addr_next;
      wb_ack_o <= ack_next;
      wb_dat_o <= dat_next;
      // open drain: output level fixed low, only enable moves
      irq_n_o <= 1'b0;
      irq_n_oe <= ~irq_next;
      pwr_reg <= pwr_next;
    end
  end

  assign power_on_req = pwr_reg;

  // ---------------------------------------------------------------
  // user ram and wipe sequencer
  // ---------------------------------------------------------------
  logic [7:0] ram_mem [0:RAM_DEPTH-1];
  wirc_pkg::wirc_wipe_t wst_reg;
  wirc_pkg::wirc_wipe_t wst_next;
  logic [7:0] wptr_reg;
  logic [7:0] wptr_next;
  logic busy_reg;
  logic busy_next;
  logic [7:0] ram_wa;
  logic [7:0] ram_wd;
  logic ram_we;
  logic ram_wr_bus;

  // ram window: word at ADDR_RAM_BASE holds index in bits 15:8 on write
  assign ram_wr_bus = wr_ok & (wb_adr_i == wirc_pkg::ADDR_RAM_BASE) & ~busy_reg;
  assign ram_rd = ram_mem[wptr_reg];

  always_comb begin
    wst_next = wst_reg;
    wptr_next = wptr_reg;
    wipe_done_ev = 1'b0;
    ram_we = 1'b0;
    ram_wa = wb_dat_i[15:8];
    ram_wd = wb_dat_i[7:0];
    case (wst_reg)
      wirc_pkg::WIRC_WIPE_IDLE: begin
        // wipe when enabled, on main or backup power alike
        if (!sync2_reg.wipe_n && ctrl_reg[wirc_pkg::CTRL_WIPE_EN]) begin
          wst_next = wirc_pkg::WIRC_WIPE_RUN;
          wptr_next = 8'h00;
        end else if (ram_wr_bus) begin
          ram_we = 1'b1;
          wptr_next = wb_dat_i[15:8];
        end
      end
      wirc_pkg::WIRC_WIPE_RUN: begin
        ram_we = 1'b1;
        ram_wa = wptr_reg;
        ram_wd = wirc_pkg::WIPE_VALUE;
        wptr_next = wptr_reg + 8'h01;
        if (wptr_reg == wirc_pkg::RAM_LAST) begin
          wst_next = wirc_pkg::WIRC_WIPE_HOLD;
          wptr_next = 8'h00;
          wipe_done_ev = 1'b1;
        end
      end
      wirc_pkg::WIRC_WIPE_HOLD: begin
        // one wipe per press: wait for release
        if (sync2_reg.wipe_n) begin
          wst_next = wirc_pkg::WIRC_WIPE_IDLE;
        end
      end
      default: wst_next = wirc_pkg::WIRC_WIPE_IDLE;
    endcase
    busy_next = (wst_next == wirc_pkg::WIRC_WIPE_RUN);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wst_reg <= wirc_pkg::WIRC_WIPE_IDLE;
      wptr_reg <= 8'h00;
      busy_reg <= 1'b0;
    end else begin
      wst_reg <= wst_next;
      wptr_reg <= wptr_next;
      busy_reg <= busy_next;
    end
  end

  // ram array has no reset; writes only
  always_ff @(posedge clk) begin
    if (ram_we && ram_wa < 8'(RAM_DEPTH)) begin
      ram_mem[ram_wa] <= ram_wd;
    end
  end

  assign wipe_busy = busy_reg;

endmodule : wirc_ctrl

// ---- testbench/wirc_ctrl_sva.sv ----
// concurrent checks on the controller ports
`timescale 1ns/1ps
module wirc_ctrl_sva (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic chip_sel_n,
  input wire logic main_supply_ok,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic irq_n_o,
  input wire logic power_on_req,
  input wire logic wipe_busy
);
  // ----------------------------------------
  // bus and pin relations
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic take;
  // request taken on this edge
  assign take = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  logic [8:0] busy_cnt;
  // sweep length counter: far too long for a repetition count
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      busy_cnt <= 9'h000;
    end else if (wipe_busy) begin
      busy_cnt <= busy_cnt + 9'h001;
    end else begin
      busy_cnt <= 9'h000;
    end
  end
  property p_drain; $past(reset_n) |-> irq_n_o == 1'b0; endproperty
  a_drain: assert property (p_drain) else $error("irq data high");
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_ack_lat; take |=> wb_ack_o; endproperty
  a_ack_lat: assert property (p_ack_lat) else $error("ack missing");
  property p_ack_cause; wb_ack_o |-> $past(take); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("stray ack");
  property p_csel; take && !wb_we_i && chip_sel_n |=> wb_dat_o == 32'h0; endproperty
  a_csel: assert property (p_csel) else $error("data while deselected");
  property p_fail_rd; !main_supply_ok [*6] ##0 (take && !wb_we_i) |=> wb_dat_o == 32'h0;
  endproperty
  a_fail_rd: assert property (p_fail_rd) else $error("read on failed supply");
  property p_pwr_clr; main_supply_ok [*8] |-> !power_on_req; endproperty
  a_pwr_clr: assert property (p_pwr_clr) else $error("power request on main");
  property p_wipe_len; $fell(wipe_busy) |-> busy_cnt == 9'(wirc_pkg::RAM_BYTES); endproperty
  a_wipe_len: assert property (p_wipe_len) else $error("wipe too short");
endmodule : wirc_ctrl_sva
bind wirc_ctrl wirc_ctrl_sva u_sva (.clk(clk), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .chip_sel_n(chip_sel_n),
  .main_supply_ok(main_supply_ok), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .irq_n_o(irq_n_o), .power_on_req(power_on_req), .wipe_busy(wipe_busy));

// ---- testbench/wirc_pin_model.sv ----
// key switch and host interrupt input model
`timescale 1ns/1ps
module wirc_pin_model (
  input wire logic press,
  input wire logic aux_backup_supply,
  input wire logic irq_n_o,
  input wire logic irq_n_oe,
  output logic key_wake_n,
  output logic irq_line
);
  assign key_wake_n = press ? 1'b0 : aux_backup_supply;
  // host pull-up, pin only pulled low
  assign irq_line = (irq_n_oe === 1'b1 && irq_n_o === 1'b0) ? 1'b0 : 1'b1;
endmodule : wirc_pin_model

// ---- testbench/wirc_ctrl_tb.sv ----
// self-checking bench for the wake, interrupt and ram-wipe controller
`timescale 1ns/1ps
module wirc_ctrl_tb;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, csel_n = 1'b0;
  logic main_ok = 1'b1, aux = 1'b1, press = 1'b0, wipe_n = 1'b1, wipe_pu = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'hF;
  logic [3:0] sel_use = 4'hF;
  logic [31:0] dat = 32'h0, rd, wb_dat_o;
  logic wb_ack_o, irq_n_o, irq_n_oe, power_on_req, wipe_busy, key_n, irq_line;
  int bad_count = 0;
  int n_checks = 0;
  always #2.5 clk = ~clk;
  wirc_ctrl dut (.clk(clk), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_sel_i(sel), .wb_adr_i(adr), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .chip_sel_n(csel_n), .main_supply_ok(main_ok),
    .aux_backup_supply(aux), .key_wake_n(key_n), .user_ram_wipe_n(wipe_n),
    .user_ram_wipe_pu(wipe_pu), .irq_n_o(irq_n_o), .irq_n_oe(irq_n_oe),
    .power_on_req(power_on_req), .wipe_busy(wipe_busy));
  wirc_pin_model u_pins (.press(press), .aux_backup_supply(aux), .irq_n_o(irq_n_o),
    .irq_n_oe(irq_n_oe), .key_wake_n(key_n), .irq_line(irq_line));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task finish_test;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : finish_test
  // classic single cycle; ack and read data are taken at the same rising edge
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= sel_use;
    adr <= a;
    dat <= d;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (wb_ack_o !== 1'b1 && i < 20);
    rd = wb_dat_o;
    if (wb_ack_o !== 1'b1) begin
      bad_count++;
      finish_test();
    end
    // release at the ack edge; the next call leaves one idle cycle
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  // pin levels, then enough edges for sync, detect and status
  task pins(input logic m, input logic p, input logic w, input logic pu);
    @(posedge clk);
    main_ok <= m; press <= p; wipe_n <= w; wipe_pu <= pu;
    repeat (10) @(posedge clk);
  endtask : pins
  task wait_busy(input logic lvl);
    int i;
    i = 0;
    while (wipe_busy !== lvl && i < 400) begin @(negedge clk); i++; end
    if (i >= 400) begin bad_count++; finish_test(); end
  endtask : wait_busy
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    // synchronised main supply must be seen before the bus is live
    repeat (4) @(posedge clk);
    // key interrupt on main supply, one event per fall
    wb(1'b1, wirc_pkg::ADDR_CTRL, 32'h3);
    wb(1'b1, wirc_pkg::ADDR_MASK, 32'h1);
    pins(1'b1, 1'b1, 1'b1, 1'b0);
    check("irq_line", irq_line, 1'b0);
    check("power_on_req", power_on_req, 1'b0);
    wb(1'b0, wirc_pkg::ADDR_STATUS, 32'h0);
    check("status", rd[2:0], 3'h1);
    pins(1'b1, 1'b1, 1'b1, 1'b0);
    check("irq_line", irq_line, 1'b1);
    wb(1'b0, wirc_pkg::ADDR_STATUS, 32'h0);
    check("status", rd[2:0], 3'h0);
    // masked event sets status but not the pin
    wb(1'b1, wirc_pkg::ADDR_MASK, 32'h0);
    pins(1'b1, 1'b0, 1'b1, 1'b0);
    pins(1'b1, 1'b1, 1'b1, 1'b0);
    check("irq_line", irq_line, 1'b1);
    wb(1'b0, wirc_pkg::ADDR_STATUS, 32'h0);
    check("status", rd[2:0], 3'h1);
    // deselected cycles: address kept, no data either way
    @(posedge clk);
    csel_n <= 1'b1;
    wb(1'b0, wirc_pkg::ADDR_CTRL, 32'h0);
    check("ctrl_desel", rd, 32'h0);
    wb(1'b1, wirc_pkg::ADDR_MASK, 32'h7);
    @(posedge clk);
    csel_n <= 1'b0;
    wb(1'b0, wirc_pkg::ADDR_LAST_ADDR, 32'h0);
    check("last_addr", rd[7:0], wirc_pkg::ADDR_MASK);
    wb(1'b0, wirc_pkg::ADDR_MASK, 32'h0);
    check("mask", rd[2:0], 3'h0);
    // a write without the low byte lane leaves the enables alone
    sel_use = 4'hE;
    wb(1'b1, wirc_pkg::ADDR_MASK, 32'h7);
    sel_use = 4'hF;
    wb(1'b0, wirc_pkg::ADDR_MASK, 32'h0);
    check("mask_sel", rd[2:0], 3'h0);
    // key enable clear: no power request on backup
    wb(1'b1, wirc_pkg::ADDR_CTRL, 32'h1);
    pins(1'b1, 1'b0, 1'b1, 1'b0);
    pins(1'b0, 1'b0, 1'b1, 1'b0);
    pins(1'b0, 1'b1, 1'b1, 1'b0);
    check("power_on_req", power_on_req, 1'b0);
    wb(1'b0, wirc_pkg::ADDR_CTRL, 32'h0);
    check("ctrl", rd, 32'h0);
    // both enables set: power request, cleared when main returns
    pins(1'b1, 1'b0, 1'b1, 1'b0);
    wb(1'b1, wirc_pkg::ADDR_CTRL, 32'h3);
    pins(1'b0, 1'b0, 1'b1, 1'b0);
    pins(1'b0, 1'b1, 1'b1, 1'b0);
    check("power_on_req", power_on_req, 1'b1);
    pins(1'b1, 1'b0, 1'b1, 1'b0);
    check("power_on_req", power_on_req, 1'b0);
    // no power request while the aux supply is missing
    pins(1'b0, 1'b0, 1'b1, 1'b0);
    @(posedge clk);
    aux <= 1'b0;
    repeat (10) @(posedge clk);
    check("power_on_req", power_on_req, 1'b0);
    aux <= 1'b1;
    pins(1'b1, 1'b0, 1'b1, 1'b0);
    // open pin with pull-up does not wipe
    wb(1'b1, wirc_pkg::ADDR_CTRL, 32'h7);
    wb(1'b1, wirc_pkg::ADDR_RAM_BASE, 32'h0000_053C);
    wb(1'b0, wirc_pkg::ADDR_RAM_BASE, 32'h0);
    check("ram", rd[7:0], 8'h3C);
    pins(1'b0, 1'b0, 1'b0, 1'b1);
    check("wipe_busy", wipe_busy, 1'b0);
    // wipe on backup power fills with ones
    pins(1'b0, 1'b0, 1'b0, 1'b0);
    wait_busy(1'b1);
    wait_busy(1'b0);
    pins(1'b1, 1'b0, 1'b1, 1'b0);
    wb(1'b0, wirc_pkg::ADDR_RAM_BASE, 32'h0);
    check("ram", rd[7:0], wirc_pkg::WIPE_VALUE);
    wb(1'b0, wirc_pkg::ADDR_STATUS, 32'h0);
    check("wipe_done", rd[2], 1'b1);
    finish_test();
  end
endmodule : wirc_ctrl_tb
